//--- shared/led_mode_pkg.sv
// Package: constants, modes and carrier structs for the LED driver mode control
package led_mode_pkg;
  localparam int STRINGS        = 4;
  localparam int ADC_BITS       = 7;
  localparam int CUR_BITS       = 5;
  localparam int REF_BITS       = 7;
  localparam logic [6:0] REF_DEFAULT = 7'h7f;  // Full scale code stands for the 1.25V reference
  localparam logic [4:0] CUR_DEFAULT = 5'h1f;
  localparam int SS_BITS        = 8;
  localparam logic [7:0] SS_FULL     = 8'hff;
  // Serial command codes carried on cmd_code
  localparam logic [2:0] CMD_NONE       = 3'h0;
  localparam logic [2:0] CMD_IDLE_ENTER = 3'h1;
  localparam logic [2:0] CMD_IDLE_EXIT  = 3'h2;
  localparam logic [2:0] CMD_SET_CUR    = 3'h3;
  localparam logic [2:0] CMD_SET_REF    = 3'h4;

  // Gray coded along normal -> lockout -> thermal -> idle -> ovp -> power down
  typedef enum logic [2:0] {
    MODE_NORMAL     = 3'h0,
    MODE_LOW_SUPPLY = 3'h1,
    MODE_THERMAL    = 3'h3,
    MODE_IDLE_HOLD  = 3'h2,
    MODE_OVERVOLT   = 3'h6,
    MODE_POWER_DOWN = 3'h7
  } mode_e;

  typedef struct packed {
    logic supply_low;
    logic supply_ok;
    logic temp_hot;
    logic temp_cool;
    logic output_overvoltage;
    logic cs_primary;
    logic cs_secondary;
  } analog_flags_s;

  typedef struct packed {
    logic       valid;
    logic [2:0] code;
    logic [1:0] index;
    logic [6:0] data;
  } serial_cmd_s;
endpackage

//--- logic/edge_sync.sv
// Two-stage synchroniser with a rising edge pulse on the synchronised level
`timescale 1ns/10ps
module edge_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] prev;

  initial begin
    if (WIDTH < 1) $error("WIDTH must be positive");
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      prev   <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      prev   <= stage2;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~prev;
endmodule // edge_sync

//--- logic/led_mode_control.sv
// Mode control for a four-string LED driver: modes, gating, soft-start and current limits
//
// Function
// - Reset lands in power down with sinks off, left once enable is high; six modes exist.
// - Supply below falling threshold locks out sinks and switcher until rising threshold.
// - Over-temperature stops sinks and switcher until die cools by hysteresis.
// - Enable pin low forces power down of everything but shunt clamp.
// - Enable high or clocked leaves power down immediately.
// - Serial command enters idle hold; sinks and switcher off, bias stays on.
// - Only the serial exit command leaves idle hold.
// - Any switcher deactivation discharges soft-start for a full restart.
// - Overvoltage latches gate drive off; cleared by enable toggle, power, idle hold.
// - Primary current limit holds gate off for rest of switching cycle.
// - Secondary limit ends cycle, discharges soft-start, restarts with soft-start.
// - Serial writes set each string current and regulator setting any time.
// - Converted drain voltage of every sink readable over serial interface.
// - Reference defaults to full value; writes may set any value up to it.
// - Readback of drain voltages lets the host detect shorts and opens.
// - External clock on enable starts each switching cycle on its rising edge.
// - Measurements, including output voltage, reported at seven-bit resolution.
`timescale 1ns/10ps
module led_mode_control #(
  parameter int OSC_DIV = 200
) (
  input  wire logic                                      ref_clk,
  input  wire logic                                      rst_n,
  input  wire logic                                      enable_sync_input,
  input  wire led_mode_pkg::analog_flags_s               flags_async,
  input  wire led_mode_pkg::serial_cmd_s                 cmd,
  input  wire logic [led_mode_pkg::STRINGS*led_mode_pkg::ADC_BITS-1:0] drain_adc,
  input  wire logic [led_mode_pkg::ADC_BITS-1:0]         vout_adc,
  output logic                                           switch_gate_drive,
  output logic [led_mode_pkg::STRINGS-1:0]               sink_enable,
  output logic [led_mode_pkg::STRINGS*led_mode_pkg::CUR_BITS-1:0] sink_current,
  output logic [led_mode_pkg::REF_BITS-1:0]              feedback_ref,
  output logic                                           soft_start_discharge,
  output logic [led_mode_pkg::SS_BITS-1:0]               soft_start_level,
  output logic                                           bias_enable,
  output logic [led_mode_pkg::STRINGS*led_mode_pkg::ADC_BITS-1:0] drain_report,
  output logic [led_mode_pkg::ADC_BITS-1:0]              vout_report,
  output led_mode_pkg::mode_e                            mode
);
  initial begin
    if (OSC_DIV < 2) $error("OSC_DIV must be at least 2");
  end

  // ==========================================================
  // Input synchronisation
  // ==========================================================
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] sync_level;
  logic [NSYNC-1:0] sync_rise;

  edge_sync #(.WIDTH(NSYNC)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({enable_sync_input, flags_async}),
    .level    (sync_level),
    .rise     (sync_rise)
  );

  led_mode_pkg::analog_flags_s flags;
  wire enable_level = sync_level[NSYNC-1];
  wire enable_rise  = sync_rise[NSYNC-1];
  assign flags = led_mode_pkg::analog_flags_s'(sync_level[NSYNC-2:0]);

  // ==========================================================
  // Fault latches and mode selection
  // ==========================================================
  logic low_supply;
  logic thermal;
  logic idle_hold;
  logic ovp_latch;
  logic enable_prev;
  logic power_down;

  // A low phase shorter than one internal period is a sync clock, not a shutdown request
  localparam int LOW_W = $clog2(OSC_DIV + 1);
  logic [LOW_W-1:0] low_count;
  wire low_full        = low_count == LOW_W'(OSC_DIV - 1);
  wire next_power_down = !enable_level && (power_down || low_full);

  wire cmd_idle_enter = cmd.valid && cmd.code == led_mode_pkg::CMD_IDLE_ENTER;
  wire cmd_idle_exit  = cmd.valid && cmd.code == led_mode_pkg::CMD_IDLE_EXIT;
  wire enable_fall    = enable_prev && !enable_level;
  // Shutdown by enable, idle hold entry or power cycle (reset) clear the overvoltage latch
  wire ovp_clear      = power_down || idle_hold || cmd_idle_enter;

  wire next_low_supply = flags.supply_low ? 1'b1 : (flags.supply_ok ? 1'b0 : low_supply);
  wire next_thermal    = flags.temp_hot ? 1'b1 : (flags.temp_cool ? 1'b0 : thermal);
  // Set wins over clear so an overvoltage in the clearing cycle is not lost
  wire next_ovp        = flags.output_overvoltage || (ovp_latch && !ovp_clear);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_supply  <= 1'b0;
      thermal     <= 1'b0;
      idle_hold   <= 1'b0;
      ovp_latch   <= 1'b0;
      enable_prev <= 1'b0;
      power_down  <= 1'b1;
      low_count   <= '0;
    end else begin
      power_down  <= next_power_down;
      low_count   <= enable_level ? '0 : (low_full ? low_count : low_count + LOW_W'(1));
      low_supply  <= next_low_supply;
      thermal     <= next_thermal;
      ovp_latch   <= next_ovp;
      enable_prev <= enable_level;
      if (cmd_idle_enter) begin
        idle_hold <= 1'b1;
      end else if (cmd_idle_exit) begin
        idle_hold <= 1'b0;
      end
    end
  end

  // Power down outranks everything; supply, thermal and idle latches stay set underneath it, overvoltage clears
  led_mode_pkg::mode_e next_mode;
  assign next_mode = power_down    ? led_mode_pkg::MODE_POWER_DOWN :
                     low_supply    ? led_mode_pkg::MODE_LOW_SUPPLY :
                     thermal       ? led_mode_pkg::MODE_THERMAL    :
                     idle_hold     ? led_mode_pkg::MODE_IDLE_HOLD  :
                     ovp_latch     ? led_mode_pkg::MODE_OVERVOLT   :
                                     led_mode_pkg::MODE_NORMAL;

  // Sinks stay off while any sink-disabling condition remains
  wire sinks_off   = power_down || low_supply || thermal || idle_hold;
  wire switch_off  = sinks_off || ovp_latch;

  // ==========================================================
  // Switching cycle timing
  // ==========================================================
  localparam int DIV_W = $clog2(OSC_DIV + 1);
  logic [DIV_W-1:0] osc_count;
  logic             ext_sync;
  logic             cycle_start;

  wire osc_wrap = osc_count == DIV_W'(OSC_DIV - 1);
  // A rising edge after a fall within the current internal period means an external clock is present
  wire ext_edge = enable_rise && enable_prev == 1'b0 && ext_sync;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_count   <= '0;
      ext_sync    <= 1'b0;
      cycle_start <= 1'b0;
    end else begin
      if (enable_fall) begin
        ext_sync <= 1'b1;
      end else if (osc_wrap) begin
        ext_sync <= 1'b0;
      end
      // An external edge restarts the internal period so sync overrides it
      if (enable_rise || osc_wrap) begin
        osc_count <= '0;
      end else begin
        osc_count <= osc_count + DIV_W'(1);
      end
      cycle_start <= ext_edge || (osc_wrap && !ext_sync);
    end
  end

  // ==========================================================
  // Soft-start and gate drive
  // ==========================================================
  logic cycle_block;

  wire ss_discharge = switch_off || flags.cs_secondary;
  // A limit hit in the cycle-start cycle still blocks: set wins over clear
  wire next_block   = flags.cs_primary ? 1'b1 : (cycle_start ? 1'b0 : cycle_block);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_block          <= 1'b0;
      soft_start_level     <= '0;
      soft_start_discharge <= 1'b1;
      switch_gate_drive    <= 1'b0;
    end else begin
      cycle_block          <= next_block;
      soft_start_discharge <= ss_discharge;
      if (ss_discharge) begin
        soft_start_level <= '0;
      end else if (cycle_start && soft_start_level != led_mode_pkg::SS_FULL) begin
        soft_start_level <= soft_start_level + 8'h01;
      end
      // Gate on from cycle start until a limit or disable ends the on-time
      if (ss_discharge || flags.cs_primary) begin
        switch_gate_drive <= 1'b0;
      end else if (cycle_start && soft_start_level != '0) begin
        switch_gate_drive <= 1'b1;
      end else if (next_block) begin
        switch_gate_drive <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Serial settings and measurement readback
  // ==========================================================
  logic [led_mode_pkg::STRINGS*led_mode_pkg::CUR_BITS-1:0] cur_regs;
  logic [led_mode_pkg::REF_BITS-1:0]                       ref_reg;

  wire set_ref_ok = cmd.valid && cmd.code == led_mode_pkg::CMD_SET_REF
                    && cmd.data <= led_mode_pkg::REF_DEFAULT;

  genvar gi;
  generate
    for (gi = 0; gi < led_mode_pkg::STRINGS; gi++) begin : g_str
      wire hit = cmd.valid && cmd.code == led_mode_pkg::CMD_SET_CUR && cmd.index == 2'(gi);
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          cur_regs[gi*led_mode_pkg::CUR_BITS +: led_mode_pkg::CUR_BITS] <= led_mode_pkg::CUR_DEFAULT;
        end else if (hit) begin
          cur_regs[gi*led_mode_pkg::CUR_BITS +: led_mode_pkg::CUR_BITS] <=
            cmd.data[led_mode_pkg::CUR_BITS-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_reg      <= led_mode_pkg::REF_DEFAULT;
      sink_enable  <= '0;
      sink_current <= '0;
      feedback_ref <= led_mode_pkg::REF_DEFAULT;
      bias_enable  <= 1'b0;
      drain_report <= '0;
      vout_report  <= '0;
      mode         <= led_mode_pkg::MODE_NORMAL;
    end else begin
      if (set_ref_ok) begin
        ref_reg <= cmd.data;
      end
      sink_enable  <= {led_mode_pkg::STRINGS{!sinks_off}};
      sink_current <= cur_regs;
      feedback_ref <= ref_reg;
      bias_enable  <= !power_down;
      drain_report <= drain_adc;
      vout_report  <= vout_adc;
      mode         <= next_mode;
    end
  end
endmodule // led_mode_control

//--- testbench/led_mode_chk.sv
// Checker: port-level properties of the LED driver mode control
`timescale 1ns/10ps
module led_mode_chk (
  input wire logic                        ref_clk,
  input wire logic                        rst_n,
  input wire logic                        enable_sync_input,
  input wire led_mode_pkg::analog_flags_s flags_async,
  input wire led_mode_pkg::serial_cmd_s   cmd,
  input wire logic [27:0]                 drain_adc,
  input wire logic [6:0]                  vout_adc,
  input wire logic                        switch_gate_drive,
  input wire logic [3:0]                  sink_enable,
  input wire logic [19:0]                 sink_current,
  input wire logic [6:0]                  feedback_ref,
  input wire logic                        soft_start_discharge,
  input wire logic [7:0]                  soft_start_level,
  input wire logic                        bias_enable,
  input wire logic [27:0]                 drain_report,
  input wire logic [6:0]                  vout_report,
  input wire led_mode_pkg::mode_e         mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Mode gating
  a_idle_gates_off: assert property (mode == led_mode_pkg::MODE_IDLE_HOLD |-> sink_enable == 4'h0 && bias_enable)
    else $error("idle hold left sinks on or bias off");
  a_off_discharge: assert property (mode != led_mode_pkg::MODE_NORMAL |-> soft_start_discharge && !switch_gate_drive)
    else $error("switcher off without soft-start discharge");
  a_lockout_sinks: assert property (mode inside {led_mode_pkg::MODE_LOW_SUPPLY, led_mode_pkg::MODE_THERMAL,
    led_mode_pkg::MODE_POWER_DOWN} |-> sink_enable == 4'h0)
    else $error("sinks on in a disabling mode");
  a_idle_enter: assert property (cmd.valid && cmd.code == led_mode_pkg::CMD_IDLE_ENTER && enable_sync_input &&
    mode == led_mode_pkg::MODE_NORMAL && flags_async == '0 |-> ##2 mode == led_mode_pkg::MODE_IDLE_HOLD)
    else $error("idle command not obeyed in two cycles");
  a_idle_exit: assert property ($fell(mode == led_mode_pkg::MODE_IDLE_HOLD) && mode == led_mode_pkg::MODE_NORMAL
    |-> $past(cmd.valid && cmd.code == led_mode_pkg::CMD_IDLE_EXIT, 2))
    else $error("idle hold left without exit command");
  // ==========
  // Serial settings and readback
  a_ref_apply: assert property (cmd.valid && cmd.code == led_mode_pkg::CMD_SET_REF
    |-> ##2 feedback_ref == $past(cmd.data, 2))
    else $error("reference write not applied");
  a_cur_apply: assert property (cmd.valid && cmd.code == led_mode_pkg::CMD_SET_CUR
    |-> ##2 sink_current[$past(cmd.index, 2) * 5 +: 5] == $past(cmd.data[4:0], 2))
    else $error("string current write not applied");
  a_report_copy: assert property ($past(rst_n) |-> drain_report == $past(drain_adc) &&
    vout_report == $past(vout_adc))
    else $error("measurement report stale");
  // ==========
  // Limits and enable; five limit samples cover the synchroniser and the register
  a_sec_limit: assert property (flags_async.cs_secondary [*5] |-> soft_start_level == 8'h0 && !switch_gate_drive)
    else $error("secondary limit did not reset soft-start");
  // Twelve low samples cover sync, the low-time filter at the bench period of 8 and the register
  a_power_down: assert property (!enable_sync_input [*8] ##1 !enable_sync_input [*4]
    |-> mode == led_mode_pkg::MODE_POWER_DOWN && !bias_enable)
    else $error("enable low did not power down");
endmodule // led_mode_chk

bind led_mode_control led_mode_chk i_chk (.*);

//--- testbench/serial_host_model.sv
// Partner model: microcontroller issuing decoded serial commands
`timescale 1ns/10ps
module serial_host_model (
  input  wire logic                 ref_clk,
  output led_mode_pkg::serial_cmd_s cmd
);
  initial cmd = '0;
  // No back-pressure exists, so each command is a single-cycle pulse
  task automatic send(input logic [2:0] code, input logic [1:0] index, input logic [6:0] data);
    @(posedge ref_clk);
    cmd <= '{1'b1, code, index, data};
    @(posedge ref_clk);
    cmd <= '0;
  endtask
endmodule // serial_host_model

//--- testbench/tb_top.sv
// Testbench: directed scenarios for the LED driver mode control
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t %h %h", $time, g, e); end end
module tb_top;
  logic                        ref_clk = 1'b0;
  logic                        rst_n = 1'b0;
  logic                        enable_sync_input = 1'b1;
  led_mode_pkg::analog_flags_s flags = '0;
  led_mode_pkg::serial_cmd_s   cmd;
  logic [27:0]                 drain_adc = '0;
  logic [27:0]                 drain_report;
  logic [6:0]                  vout_adc = '0;
  logic [6:0]                  vout_report;
  logic [6:0]                  feedback_ref;
  logic [19:0]                 sink_current;
  logic [3:0]                  sink_enable;
  logic [7:0]                  ss_level;
  logic                        gate;
  logic                        ss_dis;
  logic                        bias;
  led_mode_pkg::mode_e         mode;
  int                          failures = 0;
  int                          tests_run = 0;
  int                          cycles = 0;
  serial_host_model i_host (.ref_clk(ref_clk), .cmd(cmd));
  // Short oscillator period keeps switching cycles cheap to simulate
  led_mode_control #(.OSC_DIV(8)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .enable_sync_input(enable_sync_input),
    .flags_async(flags), .cmd(cmd), .drain_adc(drain_adc), .vout_adc(vout_adc), .switch_gate_drive(gate),
    .sink_enable(sink_enable), .sink_current(sink_current), .feedback_ref(feedback_ref),
    .soft_start_discharge(ss_dis), .soft_start_level(ss_level), .bias_enable(bias),
    .drain_report(drain_report), .vout_report(vout_report), .mode(mode));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic flag(input int b, input logic v);
    @(posedge ref_clk);
    flags[b] <= v;
  endtask
  task automatic pin(input logic v);
    @(posedge ref_clk);
    enable_sync_input <= v;
  endtask
  task automatic wait_gate;
    for (int i = 0; i < 60 && gate !== 1'b1; i++) begin
      cyc(1);
    end
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    cyc(10);
    `CHK(mode, led_mode_pkg::MODE_NORMAL)
    `CHK(sink_enable, 4'hf)
    `CHK(feedback_ref, led_mode_pkg::REF_DEFAULT)
    wait_gate();
    `CHK(gate, 1'b1)
    $display("t_reset done");
  endtask
  task automatic t_idle;
    i_host.send(led_mode_pkg::CMD_IDLE_ENTER, 2'h0, 7'h0);
    cyc(2);
    `CHK(mode, led_mode_pkg::MODE_IDLE_HOLD)
    `CHK({sink_enable, gate, ss_dis, bias}, 7'h03)
    i_host.send(led_mode_pkg::CMD_SET_REF, 2'h0, 7'h7f);
    cyc(4);
    `CHK(mode, led_mode_pkg::MODE_IDLE_HOLD)
    i_host.send(led_mode_pkg::CMD_IDLE_EXIT, 2'h0, 7'h0);
    cyc(2);
    `CHK({mode, sink_enable}, {led_mode_pkg::MODE_NORMAL, 4'hf})
    $display("t_idle done");
  endtask
  task automatic t_set;
    i_host.send(led_mode_pkg::CMD_SET_REF, 2'h0, 7'h40);
    for (int i = 0; i < 4; i++) begin
      i_host.send(led_mode_pkg::CMD_SET_CUR, 2'(i), 7'(5 * i + 3));
    end
    i_host.send(3'h5, 2'h0, 7'h10);
    cyc(2);
    `CHK(feedback_ref, 7'h40)
    `CHK(sink_current, {5'd18, 5'd13, 5'd8, 5'd3})
    $display("t_set done");
  endtask
  task automatic t_lock(input int s, input int c, input led_mode_pkg::mode_e m);
    flag(s, 1'b1);
    cyc(6);
    `CHK(mode, m)
    `CHK({sink_enable, gate, ss_dis}, 6'h01)
    flag(s, 1'b0);
    cyc(6);
    `CHK(mode, m)
    flag(c, 1'b1);
    cyc(6);
    `CHK(mode, led_mode_pkg::MODE_NORMAL)
    flag(c, 1'b0);
    $display("t_lock done");
  endtask
  task automatic t_ovp;
    flag(2, 1'b1);
    flag(2, 1'b0);
    cyc(20);
    `CHK({mode, gate}, {led_mode_pkg::MODE_OVERVOLT, 1'b0})
    pin(1'b0);
    cyc(12);
    `CHK({mode, bias}, {led_mode_pkg::MODE_POWER_DOWN, 1'b0})
    pin(1'b1);
    cyc(6);
    `CHK(mode, led_mode_pkg::MODE_NORMAL)
    flag(2, 1'b1);
    flag(2, 1'b0);
    cyc(6);
    `CHK(mode, led_mode_pkg::MODE_OVERVOLT)
    i_host.send(led_mode_pkg::CMD_IDLE_ENTER, 2'h0, 7'h0);
    i_host.send(led_mode_pkg::CMD_IDLE_EXIT, 2'h0, 7'h0);
    cyc(3);
    `CHK(mode, led_mode_pkg::MODE_NORMAL)
    $display("t_ovp done");
  endtask
  task automatic t_limits;
    wait_gate();
    flag(1, 1'b1);
    cyc(4);
    `CHK(gate, 1'b0)
    flag(1, 1'b0);
    flag(0, 1'b1);
    cyc(5);
    `CHK({ss_level, gate}, 9'h0)
    flag(0, 1'b0);
    wait_gate();
    `CHK(gate, 1'b1)
    $display("t_limits done");
  endtask
  task automatic sync_period;
    pin(1'b0);
    repeat (2) @(posedge ref_clk);
    pin(1'b1);
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic t_sync;
    logic [7:0] s0;
    repeat (3) sync_period();
    #1;
    s0 = ss_level;
    repeat (4) sync_period();
    #1;
    `CHK(ss_level, s0 + 8'h04)
    `CHK({mode, bias}, {led_mode_pkg::MODE_NORMAL, 1'b1})
    $display("t_sync done");
  endtask
  task automatic t_report;
    @(posedge ref_clk);
    drain_adc <= 28'h1f3c5a7;
    vout_adc <= 7'h55;
    cyc(3);
    `CHK(drain_report, 28'h1f3c5a7)
    `CHK(vout_report, 7'h55)
    $display("t_report done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_idle();
    t_set();
    t_lock(6, 5, led_mode_pkg::MODE_LOW_SUPPLY);
    t_lock(4, 3, led_mode_pkg::MODE_THERMAL);
    t_ovp();
    t_limits();
    t_sync();
    t_report();
    conclude();
  end
endmodule // tb_top
